// ### include/hbc_pkg.sv
package hbc_pkg;

   localparam int CLK_HZ          = 20_000_000;
   localparam int CLK_PERIOD_NS   = 50;

   // PWM carrier; must sit inside the driver's accepted toggle range
   localparam int PWM_MIN_HZ      = 1_000;
   localparam int PWM_MAX_HZ      = 500_000;
   localparam int PWM_HZ          = 20_000;
   localparam int PWM_PERIOD_CYCLES = CLK_HZ / PWM_HZ;
   localparam int PWM_CNT_W       = 11;
   localparam int DUTY_W          = 8;

   // Standby low pulse used to clear a latched over-current shutdown
   localparam int RECOVER_TIME_NS = 10_000;
   localparam int RECOVER_CYCLES  =
      (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REC_CNT_W       = 8;

   localparam int NUM_CH          = 2;

   typedef enum logic [1:0] {
      HBC_MODE_STOP  = 2'b00,
      HBC_MODE_FWD   = 2'b01,
      HBC_MODE_REV   = 2'b10,
      HBC_MODE_BRAKE = 2'b11
   } hbc_mode_t;

   typedef enum logic [1:0] {
      HBC_ST_OFF     = 2'b00,
      HBC_ST_RUN     = 2'b01,
      HBC_ST_RECOVER = 2'b10
   } hbc_state_t;

   // Pin pair encoding: bit 1 is the first control input, bit 0 the second
   localparam logic [1:0] PAIR_OFF   = 2'b00;
   localparam logic [1:0] PAIR_FWD   = 2'b01;
   localparam logic [1:0] PAIR_REV   = 2'b10;
   localparam logic [1:0] PAIR_BRAKE = 2'b11;

endpackage

// ### rtl/hbc_pwm.sv
`timescale 1ns/1ps
module hbc_pwm (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic [hbc_pkg::DUTY_W-1:0]   duty,
   output logic                              pwm_on,
   output logic                              wrap
);

   localparam logic [hbc_pkg::PWM_CNT_W-1:0] LAST =
      hbc_pkg::PWM_CNT_W'(hbc_pkg::PWM_PERIOD_CYCLES - 1);
   localparam logic [hbc_pkg::PWM_CNT_W+hbc_pkg::DUTY_W-1:0] PERIOD_W =
      (hbc_pkg::PWM_CNT_W + hbc_pkg::DUTY_W)'(hbc_pkg::PWM_PERIOD_CYCLES);

   logic [hbc_pkg::PWM_CNT_W-1:0]               cnt;
   logic [hbc_pkg::PWM_CNT_W-1:0]               next_cnt;
   logic                                        next_pwm_on;
   logic                                        next_wrap;
   logic [hbc_pkg::PWM_CNT_W+hbc_pkg::DUTY_W-1:0] level;

   // Full scale duty 255 gives 996/1000 on time, never a full on period
   always_comb begin
      level = ((hbc_pkg::PWM_CNT_W + hbc_pkg::DUTY_W)'(duty) * PERIOD_W)
              >> hbc_pkg::DUTY_W;
      next_wrap = (cnt == LAST);
      next_cnt = next_wrap ? '0 : cnt + 1'b1;
      next_pwm_on = ((hbc_pkg::PWM_CNT_W + hbc_pkg::DUTY_W)'(cnt) < level);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         pwm_on <= 1'b0;
         wrap <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pwm_on <= next_pwm_on;
         wrap <= next_wrap;
      end
   end

   pwm_wrap_spacing_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      wrap |=> !wrap [*8])
      else $error("PWM period shorter than allowed");

   zero_duty_off_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (duty == '0) |=> !pwm_on)
      else $error("PWM on with zero duty");

endmodule

// ### rtl/hbc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Controller goes straight between drive states, no off gap of its own.
// - Controller pulses standby low then high to clear latched over-current.
// - Controller can also clear it by all inputs low, then resuming.
// - Controller holds inputs and standby low while supplies switch.
// - Controller toggles control inputs between 1 kHz and 500 kHz.
module hbc_ctrl (
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        power_stable,
   input  wire logic [1:0]                  mode_a,
   input  wire logic [1:0]                  mode_b,
   input  wire logic [hbc_pkg::DUTY_W-1:0]  duty_a,
   input  wire logic [hbc_pkg::DUTY_W-1:0]  duty_b,
   input  wire logic                        recover_req,
   input  wire logic                        recover_by_stop,
   output logic                             standby_n,
   output logic                             ctrl_a_first,
   output logic                             ctrl_a_second,
   output logic                             ctrl_b_first,
   output logic                             ctrl_b_second,
   output logic                             recovering
);

   localparam logic [hbc_pkg::REC_CNT_W-1:0] REC_LAST =
      hbc_pkg::REC_CNT_W'(hbc_pkg::RECOVER_CYCLES - 1);

   logic                          rst_meta;
   logic                          rst_n;
   hbc_pkg::hbc_state_t           state;
   hbc_pkg::hbc_state_t           next_state;
   logic [hbc_pkg::REC_CNT_W-1:0] rec_cnt;
   logic [hbc_pkg::REC_CNT_W-1:0] next_rec_cnt;
   logic                          rec_kind;
   logic                          next_rec_kind;
   logic                          next_standby_n;
   logic                          next_recovering;
   logic [1:0]                    pair [hbc_pkg::NUM_CH];
   logic [1:0]                    next_pair [hbc_pkg::NUM_CH];
   logic [hbc_pkg::NUM_CH-1:0]    pwm_on;
   logic [1:0]                    mode_in [hbc_pkg::NUM_CH];
   logic [hbc_pkg::DUTY_W-1:0]    duty_in [hbc_pkg::NUM_CH];
   logic                          take_req;

   // Reset released through two flops; only the second is used
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   assign mode_in[0] = mode_a;
   assign mode_in[1] = mode_b;
   assign duty_in[0] = duty_a;
   assign duty_in[1] = duty_b;

   genvar ch;
   generate
      for (ch = 0; ch < hbc_pkg::NUM_CH; ch++) begin : g_ch
         hbc_pwm u_pwm (
            .clk    (clk),
            .rst_n  (rst_n),
            .duty   (duty_in[ch]),
            .pwm_on (pwm_on[ch]),
            .wrap   ()
         );
      end
   endgenerate

   // Off phase of the carrier is short brake (slow decay). The driver
   // keeps its own dead time, so drive and brake follow back to back.
   function automatic logic [1:0] drive_pair(input logic [1:0] mode,
                                             input logic       on);
      logic [1:0] p;
      p = hbc_pkg::PAIR_OFF;
      unique case (hbc_pkg::hbc_mode_t'(mode))
         hbc_pkg::HBC_MODE_STOP:  p = hbc_pkg::PAIR_OFF;
         hbc_pkg::HBC_MODE_FWD:   p = on ? hbc_pkg::PAIR_FWD
                                         : hbc_pkg::PAIR_BRAKE;
         hbc_pkg::HBC_MODE_REV:   p = on ? hbc_pkg::PAIR_REV
                                         : hbc_pkg::PAIR_BRAKE;
         hbc_pkg::HBC_MODE_BRAKE: p = hbc_pkg::PAIR_BRAKE;
      endcase
      return p;
   endfunction

   assign take_req = (state == hbc_pkg::HBC_ST_RUN) && power_stable &&
                     recover_req;

   always_comb begin
      next_state = state;
      next_rec_cnt = rec_cnt;
      next_rec_kind = rec_kind;
      unique case (state)
         hbc_pkg::HBC_ST_OFF: begin
            if (power_stable) begin
               next_state = hbc_pkg::HBC_ST_RUN;
            end
         end
         hbc_pkg::HBC_ST_RUN: begin
            if (take_req) begin
               next_state = hbc_pkg::HBC_ST_RECOVER;
               next_rec_cnt = REC_LAST;
               next_rec_kind = recover_by_stop;
            end
         end
         hbc_pkg::HBC_ST_RECOVER: begin
            if (rec_cnt == '0) begin
               next_state = hbc_pkg::HBC_ST_RUN;
            end else begin
               next_rec_cnt = rec_cnt - 1'b1;
            end
         end
         default: next_state = hbc_pkg::HBC_ST_OFF;
      endcase
      // Supplies switching overrides everything, even a recovery
      if (!power_stable) begin
         next_state = hbc_pkg::HBC_ST_OFF;
      end
   end

   always_comb begin
      next_standby_n = 1'b0;
      next_recovering = (next_state == hbc_pkg::HBC_ST_RECOVER);
      for (int i = 0; i < hbc_pkg::NUM_CH; i++) begin
         next_pair[i] = hbc_pkg::PAIR_OFF;
      end
      unique case (next_state)
         hbc_pkg::HBC_ST_RUN: begin
            next_standby_n = 1'b1;
            for (int i = 0; i < hbc_pkg::NUM_CH; i++) begin
               next_pair[i] = drive_pair(mode_in[i], pwm_on[i]);
            end
         end
         hbc_pkg::HBC_ST_RECOVER: begin
            // Stop-all recovery keeps standby high, the other pulses it
            next_standby_n = next_rec_kind;
         end
         default: next_standby_n = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= hbc_pkg::HBC_ST_OFF;
         rec_cnt <= '0;
         rec_kind <= 1'b0;
         standby_n <= 1'b0;
         recovering <= 1'b0;
         for (int i = 0; i < hbc_pkg::NUM_CH; i++) begin
            pair[i] <= hbc_pkg::PAIR_OFF;
         end
      end else begin
         state <= next_state;
         rec_cnt <= next_rec_cnt;
         rec_kind <= next_rec_kind;
         standby_n <= next_standby_n;
         recovering <= next_recovering;
         for (int i = 0; i < hbc_pkg::NUM_CH; i++) begin
            pair[i] <= next_pair[i];
         end
      end
   end

   assign ctrl_a_first  = pair[0][1];
   assign ctrl_a_second = pair[0][0];
   assign ctrl_b_first  = pair[1][1];
   assign ctrl_b_second = pair[1][0];

   power_off_safe_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !power_stable |=> !standby_n && !ctrl_a_first && !ctrl_a_second &&
                        !ctrl_b_first && !ctrl_b_second)
      else $error("Pins not parked while supplies switch");

   standby_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (take_req && !recover_by_stop) |=> !standby_n [*8])
      else $error("Standby recovery pulse too short");

   standby_release_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (state == hbc_pkg::HBC_ST_RECOVER && rec_cnt == '0 && power_stable)
      |=> standby_n && !recovering)
      else $error("Recovery did not return to run");

   stop_all_hold_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (take_req && recover_by_stop) |=>
      (standby_n && !ctrl_a_first && !ctrl_a_second &&
       !ctrl_b_first && !ctrl_b_second) [*8])
      else $error("Stop-all recovery not held");

   fwd_no_gap_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (next_state == hbc_pkg::HBC_ST_RUN && state == hbc_pkg::HBC_ST_RUN &&
       mode_a == hbc_pkg::HBC_MODE_FWD) |=> ctrl_a_second && standby_n)
      else $error("Forward drive inserted an off gap");

   rev_drive_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (next_state == hbc_pkg::HBC_ST_RUN && mode_b == hbc_pkg::HBC_MODE_REV)
      |=> ctrl_b_first)
      else $error("Reverse drive lost first input");

   recover_cov: cover property (
      @(posedge clk) disable iff (!rst_n)
      take_req && !recover_by_stop ##1 recovering);

   stop_recover_cov: cover property (
      @(posedge clk) disable iff (!rst_n)
      take_req && recover_by_stop ##1 recovering);

   pwm_toggle_cov: cover property (
      @(posedge clk) disable iff (!rst_n)
      $rose(ctrl_a_second) ##[1:1000] $fell(ctrl_a_first));

endmodule

// ### bench/hbc_drv_model.sv
`timescale 1ns/1ps
module hbc_drv_model #(
   parameter int MASK_NS = 4000,
   parameter int DEAD_NS = 100
) (
   input  wire logic standby_n,
   input  wire logic ctrl_a_first,
   input  wire logic ctrl_a_second,
   input  wire logic ctrl_b_first,
   input  wire logic ctrl_b_second,
   input  wire logic overtemp,
   input  wire logic overcurrent,
   input  wire logic uv_logic,
   input  wire logic uv_motor,
   output logic      out_a_first,
   output logic      out_a_second,
   output logic      out_b_first,
   output logic      out_b_second
);
   logic [3:0] ctrl;
   logic [3:0] want;
   logic [3:0] late;
   logic [1:0] on;
   logic       oc_long;
   logic       oc_latched = 1'b0;
   logic       halt;
   assign ctrl = {ctrl_a_first, ctrl_a_second, ctrl_b_first, ctrl_b_second};
   // Inertial delay swallows current spikes shorter than the mask
   assign #(MASK_NS) oc_long = overcurrent;
   always @(oc_long or standby_n or ctrl) begin
      if (!standby_n || ctrl == 4'h0)
         oc_latched = 1'b0;
      else if (oc_long)
         oc_latched = 1'b1;
   end
   assign halt = !standby_n || overtemp || oc_latched || uv_logic
                 || uv_motor;
   assign on[1] = !halt && ctrl[3:2] != 2'b00;
   assign on[0] = !halt && ctrl[1:0] != 2'b00;
   assign want[3:2] = ctrl[3:2] == 2'b11 ? 2'b00 : ctrl[3:2];
   assign want[1:0] = ctrl[1:0] == 2'b11 ? 2'b00 : ctrl[1:0];
   // A leg floats until its new level has settled for the dead time
   assign #(DEAD_NS) late = want;
   assign out_a_first  = on[1] && late[3] === want[3] ? want[3] : 1'bz;
   assign out_a_second = on[1] && late[2] === want[2] ? want[2] : 1'bz;
   assign out_b_first  = on[0] && late[1] === want[1] ? want[1] : 1'bz;
   assign out_b_second = on[0] && late[0] === want[0] ? want[0] : 1'bz;
endmodule

// ### bench/hbc_ctrl_tb.sv
`timescale 1ns/1ps
module hbc_ctrl_tb;
   logic                       clk;
   logic                       reset_n;
   logic                       power_stable;
   logic [1:0]                 mode_a;
   logic [1:0]                 mode_b;
   logic [hbc_pkg::DUTY_W-1:0] duty_a;
   logic [hbc_pkg::DUTY_W-1:0] duty_b;
   logic                       recover_req;
   logic                       recover_by_stop;
   logic                       standby_n;
   logic                       ctrl_a_first;
   logic                       ctrl_a_second;
   logic                       ctrl_b_first;
   logic                       ctrl_b_second;
   logic                       recovering;
   logic                       overtemp;
   logic                       overcurrent;
   logic                       uv_logic;
   logic                       uv_motor;
   logic                       out_a_first;
   logic                       out_a_second;
   logic                       out_b_first;
   logic                       out_b_second;
   int                         err_total = 0;
   int                         compares = 0;
   int                         cycles = 0;
   wire  [4:0]                 pins = {standby_n, ctrl_a_first,
                                  ctrl_a_second, ctrl_b_first, ctrl_b_second};
   wire  [9:0]                 outs = {6'h00, out_a_first, out_a_second,
                                  out_b_first, out_b_second};

   hbc_ctrl u_hbc_ctrl (
      .clk, .reset_n, .power_stable, .mode_a, .mode_b, .duty_a, .duty_b,
      .recover_req, .recover_by_stop, .standby_n, .ctrl_a_first,
      .ctrl_a_second, .ctrl_b_first, .ctrl_b_second, .recovering
   );
   hbc_drv_model u_hbc_drv_model (
      .standby_n, .ctrl_a_first, .ctrl_a_second, .ctrl_b_first,
      .ctrl_b_second, .overtemp, .overcurrent, .uv_logic, .uv_motor,
      .out_a_first, .out_a_second, .out_b_first, .out_b_second
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Ceiling is about twice the length of the full sequence
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         results();
      end
   end

   task automatic chk(input string what, input logic [9:0] exp,
                      input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         mode_a = 2'(m);
         mode_b = 2'(3 - m);
         tick(5);
         chk("pins a", 10'(m), 10'(pins[3:2] & (m == 0 ? 2'b11 : 2'(m))));
         chk("pins b", 10'(3 - m),
             10'(pins[1:0] & (m == 3 ? 2'b11 : 2'(3 - m))));
         if (m == 0)
            chk("outs", {6'h00, 4'bzz00}, outs);
      end
   endtask

   task automatic t_pwm();
      int   lo;
      int   gap;
      int   edges;
      logic prev;
      lo = 0;
      gap = 0;
      edges = 0;
      mode_a = 2'b01;
      mode_b = 2'b00;
      tick(5);
      prev = ctrl_a_first;
      repeat (1000) begin
         tick(1);
         lo += int'(ctrl_a_first === 1'b0);
         gap += int'(ctrl_a_second !== 1'b1);
         edges += int'(ctrl_a_first !== prev);
         prev = ctrl_a_first;
      end
      chk("fwd on cycles", 10'd500, 10'(lo));
      chk("fwd edges", 10'd2, 10'(edges));
      chk("fwd gaps", 10'd0, 10'(gap));
      // Zero duty must leave the leg in brake for each of the 50 cycles sampled
      duty_a = 8'h00;
      tick(5);
      lo = 0;
      repeat (50) begin
         tick(1);
         lo += int'(ctrl_a_first !== 1'b1);
      end
      chk("zero duty on cycles", 10'd0, 10'(lo));
      duty_a = 8'h80;
   endtask

   task automatic t_recover(input logic kind);
      int n;
      n = 0;
      mode_a = 2'b11;
      mode_b = 2'b11;
      overcurrent = 1'b1;
      tick(40);
      overcurrent = 1'b0;
      tick(5);
      chk("outs after spike", 10'h000, outs);
      overcurrent = 1'b1;
      tick(120);
      overcurrent = 1'b0;
      tick(5);
      chk("outs latched", {6'h00, 4'bzzzz}, outs);
      recover_req = 1'b1;
      recover_by_stop = kind;
      tick(1);
      recover_req = 1'b0;
      chk("recover pins", kind ? 10'h010 : 10'h000, 10'(pins));
      while (recovering === 1'b1 && n < 300) begin
         n++;
         tick(1);
      end
      chk("recover length", 10'd200, 10'(n));
      tick(5);
      chk("outs resumed", 10'h000, outs);
   endtask

   task automatic t_faults();
      for (int i = 0; i < 3; i++) begin
         {overtemp, uv_logic, uv_motor} = 3'b100 >> i;
         tick(3);
         chk("outs fault", {6'h00, 4'bzzzz}, outs);
         {overtemp, uv_logic, uv_motor} = 3'b000;
         tick(3);
         chk("outs released", 10'h000, outs);
      end
   endtask

   task automatic t_power();
      power_stable = 1'b0;
      tick(1);
      chk("pins power drop", 10'h000, 10'(pins));
      power_stable = 1'b1;
      tick(3);
      chk("pins restored", 10'h01f, 10'(pins));
   endtask

   initial begin
      reset_n = 1'b0;
      power_stable = 1'b0;
      mode_a = 2'b00;
      mode_b = 2'b00;
      duty_a = 8'h80;
      duty_b = 8'h80;
      recover_req = 1'b0;
      recover_by_stop = 1'b0;
      {overtemp, overcurrent, uv_logic, uv_motor} = 4'h0;
      tick(12);
      chk("pins in reset", 10'h000, 10'(pins));
      reset_n = 1'b1;
      tick(6);
      chk("pins unpowered", 10'h000, 10'(pins));
      power_stable = 1'b1;
      tick(3);
      t_modes();
      t_pwm();
      t_recover(1'b0);
      t_recover(1'b1);
      t_faults();
      t_power();
      results();
   end
endmodule
